// File: src/eds_pkg.sv
// shared constants and types for the steered oscillator channel block
package eds_pkg;
   // ==========================================================
   // widths
   localparam int FCW_W = 42;
   localparam int STEER_W = 48;
   localparam int PCW_W = 32;
   localparam int TMR_W = 16;
   localparam int STEP_W = 32;
   localparam int STEP_CMD_W = 16;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_MS_PS = 1_000_000_000;
   localparam int MS_CYCLES = TICK_MS_PS / CLK_PERIOD_PS;
   // ==========================================================
   // register map, per channel block at 0x40 * channel
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_FCW_LO = 6'h04;
   localparam logic [5:0] OFS_FCW_HI = 6'h08;
   localparam logic [5:0] OFS_STEP = 6'h0C;
   localparam logic [5:0] OFS_PCW = 6'h10;
   localparam logic [5:0] OFS_TIMER = 6'h14;
   localparam logic [5:0] OFS_STATUS = 6'h18;
   localparam logic [5:0] OFS_STEER_LO = 6'h1C;
   localparam logic [5:0] OFS_STEER_HI = 6'h20;
   localparam logic [5:0] OFS_LF_CFG = 6'h24;
   localparam int CH_IDX_LSB = 6;
   localparam int CH_IDX_W = 2;
   localparam logic [3:0] PAGE_CH = 4'h0;
   localparam logic [3:0] PAGE_GLOBAL = 4'h1;
   localparam logic [7:0] OFS_STEP_CMD = 8'h00;
   localparam int STEP_DEC_LSB = 8;
   // ==========================================================
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TEN_BIT = 4;
   localparam int CTRL_HOLD_BIT = 5;
   localparam int CTRL_PIN_BIT = 6;
   localparam int LF_BW_LSB = 0;
   localparam int LF_SLOPE_LSB = 16;
   localparam int STAT_HOLD_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   localparam int STAT_REMAIN_LSB = 16;
   localparam logic [1:0] MODE_CODE_CLOSED = 2'h0;
   localparam logic [1:0] MODE_CODE_FREQ = 2'h1;
   localparam logic [1:0] MODE_CODE_PHASE = 2'h2;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      EDS_CLOSED = 3'b001,
      EDS_FREQ = 3'b010,
      EDS_PHASE = 3'b100
   } eds_mode_t;
   typedef enum logic [1:0] {
      EDS_T_IDLE = 2'b01,
      EDS_T_RUN = 2'b10
   } eds_tmr_t;
   typedef struct packed {
      eds_mode_t mode;
      logic timer_en;
      logic expire_hold;
      logic pin_en;
      logic [3:0] bw_shift;
      logic [15:0] slope_lim;
   } eds_cfg_t;
   typedef struct packed {
      logic load_fcw;
      logic [STEER_W-1:0] frequency_control_word;
      logic inc;
      logic dec;
      logic load_pcw;
      logic [PCW_W-1:0] phase_control_word;
      logic ms_tick;
      logic resume;
   } eds_cmd_t;
   localparam eds_cfg_t CFG_RST = '{EDS_CLOSED, 1'b0, 1'b0, 1'b0, 4'h4, 16'h0100};
endpackage

// File: src/eds_lf.sv
// digital loop filter with output slope limit
`timescale 1ns/1ps
module eds_lf (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic hold,
   input wire logic [eds_pkg::PCW_W-1:0] err,
   input wire logic [3:0] bw_shift,
   input wire logic [15:0] slope_lim,
   output logic [eds_pkg::STEER_W-1:0] freq_q
);
   // ==========================================================
   // proportional plus integral path
   logic signed [eds_pkg::STEER_W-1:0] err_x;
   logic signed [eds_pkg::STEER_W-1:0] integ_q;
   logic signed [eds_pkg::STEER_W-1:0] target;
   logic signed [eds_pkg::STEER_W-1:0] delta;
   logic signed [eds_pkg::STEER_W-1:0] lim;
   logic signed [eds_pkg::STEER_W-1:0] freq_d;
   logic [4:0] ki_shift;

   always_comb
   begin
      err_x = {{(eds_pkg::STEER_W-eds_pkg::PCW_W){err[eds_pkg::PCW_W-1]}}, err};
      ki_shift = {bw_shift, 1'b0};
      target = integ_q + (err_x >>> bw_shift);
      lim = {{(eds_pkg::STEER_W-16){1'b0}}, slope_lim};
      delta = target - $signed(freq_q);
      // narrow bandwidth and slope cap set how fast the output moves
      if (delta > lim)
      begin
         freq_d = $signed(freq_q) + lim;
      end
      else if (delta < -lim)
      begin
         freq_d = $signed(freq_q) - lim;
      end
      else
      begin
         freq_d = target;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         integ_q <= '0;
         freq_q <= '0;
      end
      else if (ce && !hold)
      begin
         integ_q <= integ_q + (err_x >>> ki_shift);
         freq_q <= freq_d;
      end
   end
endmodule

// File: src/eds_chan.sv
// one steered oscillator channel: steering source, step accumulator, phase word timer
`timescale 1ns/1ps
module eds_chan (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire eds_pkg::eds_cfg_t cfg,
   input wire eds_pkg::eds_cmd_t cmd,
   input wire logic [eds_pkg::STEP_W-1:0] step_size,
   input wire logic [eds_pkg::TMR_W-1:0] tmr_cfg,
   input wire logic [eds_pkg::STEER_W-1:0] combo_fcw,
   input wire logic [eds_pkg::PCW_W-1:0] pfd_err,
   input wire logic [eds_pkg::STEER_W-1:0] lf_freq,
   output logic [eds_pkg::PCW_W-1:0] lf_err,
   output logic hold_q,
   output logic run,
   output logic [eds_pkg::TMR_W-1:0] remain_q,
   output logic [eds_pkg::PCW_W-1:0] pcw_q,
   output logic [eds_pkg::STEER_W-1:0] acc_q,
   output logic [eds_pkg::STEER_W-1:0] steer_q
);
   // ==========================================================
   // decode
   eds_pkg::eds_tmr_t tmr_q;
   logic expire;
   logic [eds_pkg::STEER_W-1:0] step_x;
   logic [eds_pkg::STEER_W-1:0] fcw_x;

   always_comb
   begin
      step_x = {{(eds_pkg::STEER_W-eds_pkg::STEP_W){step_size[eds_pkg::STEP_W-1]}}, step_size};
      fcw_x = {{(eds_pkg::STEER_W-eds_pkg::FCW_W){cmd.frequency_control_word[eds_pkg::FCW_W-1]}},
               cmd.frequency_control_word[eds_pkg::FCW_W-1:0]};
      expire = (tmr_q == eds_pkg::EDS_T_RUN) && cmd.ms_tick && (remain_q == 16'h0001);
      run = (tmr_q == eds_pkg::EDS_T_RUN);
      // phase word enters the filter where the detector error would
      lf_err = (cfg.mode == eds_pkg::EDS_PHASE) ? pcw_q : pfd_err;
   end

   // ==========================================================
   // accumulated frequency word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_q <= '0;
      end
      else if (ce)
      begin
         if (cmd.load_fcw)
         begin
            acc_q <= fcw_x;
         end
         else if (cmd.inc && !cmd.dec)
         begin
            acc_q <= acc_q + step_x;
         end
         else if (cmd.dec && !cmd.inc)
         begin
            acc_q <= acc_q - step_x;
         end
      end
   end

   // ==========================================================
   // phase word and holdover
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pcw_q <= '0;
         hold_q <= 1'b0;
      end
      else if (ce)
      begin
         if (cmd.load_pcw)
         begin
            pcw_q <= cmd.phase_control_word;
            hold_q <= 1'b0;
         end
         else if (expire)
         begin
            if (cfg.expire_hold)
            begin
               hold_q <= 1'b1;
            end
            else
            begin
               pcw_q <= '0;
            end
         end
         else if (cmd.resume)
         begin
            hold_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // phase word timer, millisecond units
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tmr_q <= eds_pkg::EDS_T_IDLE;
         remain_q <= '0;
      end
      else if (ce)
      begin
         case (tmr_q)
            eds_pkg::EDS_T_IDLE:
            begin
               if (cmd.load_pcw && cfg.timer_en && (tmr_cfg != '0))
               begin
                  tmr_q <= eds_pkg::EDS_T_RUN;
                  remain_q <= tmr_cfg;
               end
            end
            eds_pkg::EDS_T_RUN:
            begin
               if (!cfg.timer_en)
               begin
                  tmr_q <= eds_pkg::EDS_T_IDLE;
                  remain_q <= '0;
               end
               else if (cmd.load_pcw)
               begin
                  remain_q <= tmr_cfg;
               end
               else if (cmd.ms_tick)
               begin
                  remain_q <= remain_q - 16'h0001;
                  if (expire)
                  begin
                     tmr_q <= eds_pkg::EDS_T_IDLE;
                  end
               end
            end
            default:
            begin
               tmr_q <= eds_pkg::EDS_T_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // steering word to the fractional output divider
   // registered whole word so the divider never sees a torn update
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         steer_q <= '0;
      end
      else if (ce)
      begin
         if (cfg.mode == eds_pkg::EDS_FREQ)
         begin
            steer_q <= acc_q + combo_fcw;
         end
         else
         begin
            steer_q <= lf_freq + combo_fcw;
         end
      end
   end
endmodule

// File: src/eds_top.sv
// apb register front end and channel array for external oscillator steering
`timescale 1ns/1ps
module eds_top #(
   parameter int NUM_CH = 4,
   parameter int MS_CYCLES = eds_pkg::MS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [eds_pkg::ADDR_W-1:0] paddr,
   input wire logic [eds_pkg::DATA_W-1:0] pwdata,
   output logic pready,
   output logic [eds_pkg::DATA_W-1:0] prdata,
   output logic pslverr,
   input wire logic [NUM_CH-1:0] inc_pin,
   input wire logic [NUM_CH-1:0] dec_pin,
   input wire logic [NUM_CH-1:0][eds_pkg::STEER_W-1:0] combo_fcw,
   input wire logic [NUM_CH-1:0][eds_pkg::PCW_W-1:0] pfd_err,
   output logic [NUM_CH-1:0][eds_pkg::STEER_W-1:0] steer_word,
   output logic [NUM_CH-1:0] holdover
);
   // ==========================================================
   // declarations
   localparam int MS_W = $clog2(MS_CYCLES + 1);
   localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

   logic pready_q;
   logic [eds_pkg::DATA_W-1:0] prdata_q;
   logic pslverr_q;
   logic wr_go;
   logic rd_go;
   logic ch_hit;
   logic glb_hit;
   logic [eds_pkg::CH_IDX_W-1:0] ch_idx;
   logic [5:0] reg_ofs;
   logic [eds_pkg::DATA_W-1:0] rd_data;
   logic rd_err;
   logic [MS_W-1:0] ms_cnt_q;
   logic ms_tick_q;
   logic [NUM_CH-1:0] inc_prev_q;
   logic [NUM_CH-1:0] dec_prev_q;

   eds_pkg::eds_cfg_t cfg_q [NUM_CH];
   logic [eds_pkg::DATA_W-1:0] fcw_lo_q [NUM_CH];
   logic [eds_pkg::STEP_W-1:0] step_q [NUM_CH];
   logic [eds_pkg::TMR_W-1:0] tmr_q [NUM_CH];
   eds_pkg::eds_cmd_t cmd [NUM_CH];

   logic [eds_pkg::PCW_W-1:0] lf_err [NUM_CH];
   logic [eds_pkg::STEER_W-1:0] lf_freq [NUM_CH];
   logic hold [NUM_CH];
   logic run [NUM_CH];
   logic [eds_pkg::TMR_W-1:0] remain [NUM_CH];
   logic [eds_pkg::PCW_W-1:0] phase_control_word [NUM_CH];
   logic [eds_pkg::STEER_W-1:0] acc [NUM_CH];
   logic [eds_pkg::STEER_W-1:0] steer [NUM_CH];

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // ==========================================================
   // apb access timing, one wait state on every transfer
   always_comb
   begin
      rd_go = psel && penable && !pready_q && ce;
      wr_go = psel && penable && pready_q && pwrite && ce;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end
      else if (ce)
      begin
         pready_q <= psel && penable && !pready_q;
         if (rd_go)
         begin
            prdata_q <= pwrite ? '0 : rd_data;
            pslverr_q <= rd_err;
         end
         else if (pready_q || !psel)
         begin
            // read data and error stand only in the completing cycle
            prdata_q <= '0;
            pslverr_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // address decode
   always_comb
   begin
      ch_idx = paddr[eds_pkg::CH_IDX_LSB +: eds_pkg::CH_IDX_W];
      reg_ofs = paddr[5:0];
      ch_hit = 1'b0;
      glb_hit = 1'b0;
      if (paddr[11:8] == eds_pkg::PAGE_CH && 32'(ch_idx) < NUM_CH)
      begin
         ch_hit = 1'b1;
      end
      else if (paddr[11:8] == eds_pkg::PAGE_GLOBAL && paddr[7:0] == eds_pkg::OFS_STEP_CMD)
      begin
         glb_hit = 1'b1;
      end
   end

   // ==========================================================
   // read mux, reserved bits read zero
   always_comb
   begin
      rd_data = '0;
      rd_err = 1'b0;
      if (glb_hit)
      begin
         rd_data = '0;
      end
      else if (!ch_hit)
      begin
         rd_err = 1'b1;
      end
      else if (reg_ofs == eds_pkg::OFS_CTRL)
      begin
         rd_data[eds_pkg::CTRL_MODE_LSB +: 2] =
            (cfg_q[ch_idx].mode == eds_pkg::EDS_FREQ) ? eds_pkg::MODE_CODE_FREQ :
            (cfg_q[ch_idx].mode == eds_pkg::EDS_PHASE) ? eds_pkg::MODE_CODE_PHASE : eds_pkg::MODE_CODE_CLOSED;
         rd_data[eds_pkg::CTRL_TEN_BIT] = cfg_q[ch_idx].timer_en;
         rd_data[eds_pkg::CTRL_HOLD_BIT] = cfg_q[ch_idx].expire_hold;
         rd_data[eds_pkg::CTRL_PIN_BIT] = cfg_q[ch_idx].pin_en;
      end
      else if (reg_ofs == eds_pkg::OFS_FCW_LO)
      begin
         rd_data = acc[ch_idx][31:0];
      end
      else if (reg_ofs == eds_pkg::OFS_FCW_HI)
      begin
         rd_data[15:0] = acc[ch_idx][eds_pkg::STEER_W-1:32];
      end
      else if (reg_ofs == eds_pkg::OFS_STEP)
      begin
         rd_data = step_q[ch_idx];
      end
      else if (reg_ofs == eds_pkg::OFS_PCW)
      begin
         rd_data = phase_control_word[ch_idx];
      end
      else if (reg_ofs == eds_pkg::OFS_TIMER)
      begin
         rd_data[15:0] = tmr_q[ch_idx];
      end
      else if (reg_ofs == eds_pkg::OFS_STATUS)
      begin
         rd_data[eds_pkg::STAT_HOLD_BIT] = hold[ch_idx];
         rd_data[eds_pkg::STAT_RUN_BIT] = run[ch_idx];
         rd_data[eds_pkg::STAT_REMAIN_LSB +: 16] = remain[ch_idx];
      end
      else if (reg_ofs == eds_pkg::OFS_STEER_LO)
      begin
         rd_data = steer[ch_idx][31:0];
      end
      else if (reg_ofs == eds_pkg::OFS_STEER_HI)
      begin
         rd_data[15:0] = steer[ch_idx][eds_pkg::STEER_W-1:32];
      end
      else if (reg_ofs == eds_pkg::OFS_LF_CFG)
      begin
         rd_data[eds_pkg::LF_BW_LSB +: 4] = cfg_q[ch_idx].bw_shift;
         rd_data[eds_pkg::LF_SLOPE_LSB +: 16] = cfg_q[ch_idx].slope_lim;
      end
      else
      begin
         rd_err = 1'b1;
      end
   end

   // ==========================================================
   // per channel configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            cfg_q[c] <= eds_pkg::CFG_RST;
            fcw_lo_q[c] <= '0;
            step_q[c] <= '0;
            tmr_q[c] <= '0;
         end
      end
      else if (wr_go && ch_hit)
      begin
         if (reg_ofs == eds_pkg::OFS_CTRL)
         begin
            // each channel picks its mode alone
            if (pwdata[eds_pkg::CTRL_MODE_LSB +: 2] == eds_pkg::MODE_CODE_FREQ)
            begin
               cfg_q[ch_idx].mode <= eds_pkg::EDS_FREQ;
            end
            else if (pwdata[eds_pkg::CTRL_MODE_LSB +: 2] == eds_pkg::MODE_CODE_PHASE)
            begin
               cfg_q[ch_idx].mode <= eds_pkg::EDS_PHASE;
            end
            else
            begin
               cfg_q[ch_idx].mode <= eds_pkg::EDS_CLOSED;
            end
            cfg_q[ch_idx].timer_en <= pwdata[eds_pkg::CTRL_TEN_BIT];
            cfg_q[ch_idx].expire_hold <= pwdata[eds_pkg::CTRL_HOLD_BIT];
            cfg_q[ch_idx].pin_en <= pwdata[eds_pkg::CTRL_PIN_BIT];
         end
         else if (reg_ofs == eds_pkg::OFS_FCW_LO)
         begin
            fcw_lo_q[ch_idx] <= pwdata;
         end
         else if (reg_ofs == eds_pkg::OFS_STEP)
         begin
            step_q[ch_idx] <= pwdata;
         end
         else if (reg_ofs == eds_pkg::OFS_TIMER)
         begin
            tmr_q[ch_idx] <= pwdata[eds_pkg::TMR_W-1:0];
         end
         else if (reg_ofs == eds_pkg::OFS_LF_CFG)
         begin
            cfg_q[ch_idx].bw_shift <= pwdata[eds_pkg::LF_BW_LSB +: 4];
            cfg_q[ch_idx].slope_lim <= pwdata[eds_pkg::LF_SLOPE_LSB +: 16];
         end
      end
   end

   // ==========================================================
   // millisecond tick for the phase word timers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ms_cnt_q <= '0;
         ms_tick_q <= 1'b0;
      end
      else if (ce)
      begin
         ms_tick_q <= (ms_cnt_q == MS_LAST);
         ms_cnt_q <= (ms_cnt_q == MS_LAST) ? '0 : ms_cnt_q + 1'b1;
      end
   end

   // ==========================================================
   // step pins, rising edge gives one step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         inc_prev_q <= '0;
         dec_prev_q <= '0;
      end
      else if (ce)
      begin
         inc_prev_q <= inc_pin;
         dec_prev_q <= dec_pin;
      end
   end

   // ==========================================================
   // per channel commands
   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         cmd[c] = '0;
         if (wr_go && ch_hit && 32'(ch_idx) == c)
         begin
            // high half commits the staged low half in one go
            cmd[c].load_fcw = (reg_ofs == eds_pkg::OFS_FCW_HI);
            cmd[c].load_pcw = (reg_ofs == eds_pkg::OFS_PCW);
            cmd[c].resume = (reg_ofs == eds_pkg::OFS_CTRL);
         end
         cmd[c].frequency_control_word = {pwdata[15:0], fcw_lo_q[c]};
         cmd[c].phase_control_word = pwdata;
         cmd[c].ms_tick = ms_tick_q;
         // a single step write may touch several channels at once
         cmd[c].inc = (wr_go && glb_hit && pwdata[c]) ||
                      (cfg_q[c].pin_en && inc_pin[c] && !inc_prev_q[c]);
         cmd[c].dec = (wr_go && glb_hit && pwdata[eds_pkg::STEP_DEC_LSB + c]) ||
                      (cfg_q[c].pin_en && dec_pin[c] && !dec_prev_q[c]);
      end
   end

   // ==========================================================
   // channel array
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_ch
      eds_chan u_chan (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .cfg(cfg_q[g]),
         .cmd(cmd[g]),
         .step_size(step_q[g]),
         .tmr_cfg(tmr_q[g]),
         .combo_fcw(combo_fcw[g]),
         .pfd_err(pfd_err[g]),
         .lf_freq(lf_freq[g]),
         .lf_err(lf_err[g]),
         .hold_q(hold[g]),
         .run(run[g]),
         .remain_q(remain[g]),
         .pcw_q(phase_control_word[g]),
         .acc_q(acc[g]),
         .steer_q(steer[g])
      );
      eds_lf u_lf (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .hold(hold[g]),
         .err(lf_err[g]),
         .bw_shift(cfg_q[g].bw_shift),
         .slope_lim(cfg_q[g].slope_lim),
         .freq_q(lf_freq[g])
      );
      assign steer_word[g] = steer[g];
      assign holdover[g] = hold[g];
   end
endmodule

// File: testbench/eds_chk.sv
// bus and holdover checks on the top module ports
`timescale 1ns/1ps
module eds_chk #(
   parameter int NUM_CH = 4,
   parameter int MS_CYCLES = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_CH-1:0][eds_pkg::STEER_W-1:0] steer_word,
   input wire logic [NUM_CH-1:0] holdover
);
   // ==========================================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property (psel && penable && !pready && ce |=> pready) else $error("no ready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
   a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
   a_setup_quiet: assert property (psel && !penable |-> !pready) else $error("ready in setup");
   a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("ready uncaused");
   a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
   a_reset_quiet: assert property ($rose(presetn) |-> !pready && holdover == '0 && steer_word == '0)
      else $error("dirty reset");
   // holdover leaves only through a completed write
   a_hold_keep: assert property (!(pready && pwrite) |=> (holdover & $past(holdover)) == $past(holdover))
      else $error("holdover lost");
endmodule
bind eds_top eds_chk #(.NUM_CH(NUM_CH), .MS_CYCLES(MS_CYCLES)) eds_chk_inst (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .steer_word(steer_word), .holdover(holdover));

// File: testbench/eds_host.sv
// apb host standing in for the external servo processor
`timescale 1ns/1ps
module eds_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [eds_pkg::ADDR_W-1:0] paddr,
   output logic [eds_pkg::DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic [eds_pkg::DATA_W-1:0] prdata,
   input wire logic pslverr
);
   // ==========================================
   // bus cycle, no latency assumed
   initial
   begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = '0;
      pwdata = '0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
endmodule

// File: testbench/testbench.sv
// self-checking bench for the oscillator steering block
`timescale 1ns/1ps
module testbench;
   // ==========================================
   // clock, stimulus, design
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic ce = 1'h1;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] inc_pin = 4'h0;
   logic [3:0] dec_pin = 4'h0;
   logic [3:0][47:0] combo_fcw = '0;
   logic [3:0][31:0] pfd_err = '0;
   logic [3:0][47:0] steer_word;
   logic [3:0] holdover;
   int failures = 0;
   int checks = 0;
   always #2 pclk = ~pclk;
   eds_top #(.MS_CYCLES(10)) eds_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .inc_pin(inc_pin), .dec_pin(dec_pin), .combo_fcw(combo_fcw), .pfd_err(pfd_err),
      .steer_word(steer_word), .holdover(holdover));
   eds_host eds_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   // ==========================================
   // helpers
   function automatic logic [11:0] ad(input int ch, input logic [5:0] ofs);
      return {4'h0, ch[1:0], ofs};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      eds_host_inst.xfer(1'h1, a, d, rd, err);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge pclk);
   endtask
   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ==========================================
   // scenarios
   task automatic t_freq;
      eds_host_inst.xfer(1'h0, ad(0, eds_pkg::OFS_LF_CFG), 32'h0, rd, err);
      cmp(rd, 48'h0100_0004);
      wr(ad(0, eds_pkg::OFS_CTRL), 32'h0000_0001);
      wr(ad(0, eds_pkg::OFS_FCW_LO), 32'h1234_5678);
      wt(3);
      cmp(steer_word[0], 48'h0);
      wr(ad(0, eds_pkg::OFS_FCW_HI), 32'h0000_fe00);
      wt(3);
      cmp(steer_word[0], 48'hfe00_1234_5678);
      cmp(steer_word[1], 48'h0);
      @(posedge pclk);
      ce <= 1'h0;
      combo_fcw[0] <= 48'h0000_0000_0003;
      wt(4);
      cmp(steer_word[0], 48'hfe00_1234_5678);
      @(posedge pclk);
      ce <= 1'h1;
      wt(4);
      cmp(steer_word[0], 48'hfe00_1234_567b);
      @(posedge pclk);
      combo_fcw[0] <= 48'h0;
      wt(10);
      cmp(steer_word[0], 48'hfe00_1234_5678);
      $display("frequency test done");
   endtask
   task automatic t_step;
      wr(ad(0, eds_pkg::OFS_STEP), 32'hffff_fffb);
      wr({eds_pkg::PAGE_GLOBAL, eds_pkg::OFS_STEP_CMD}, 32'h0000_0001);
      wt(3);
      cmp(steer_word[0], 48'hfe00_1234_5673);
      wr({eds_pkg::PAGE_GLOBAL, eds_pkg::OFS_STEP_CMD}, 32'h0000_0100);
      wr({eds_pkg::PAGE_GLOBAL, eds_pkg::OFS_STEP_CMD}, 32'h0000_0100);
      wt(3);
      cmp(steer_word[0], 48'hfe00_1234_567d);
      eds_host_inst.xfer(1'h0, 12'h0fc, 32'h0, rd, err);
      cmp({err, rd}, 48'h1_0000_0000);
      $display("step test done");
   endtask
   task automatic t_pin;
      wr(ad(3, eds_pkg::OFS_CTRL), 32'h0000_0041);
      wr(ad(3, eds_pkg::OFS_STEP), 32'h0000_0007);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge pclk);
         inc_pin <= (i == 0) ? 4'h8 : 4'h0;
         dec_pin <= (i == 0) ? 4'h0 : 4'h8;
         wt(2);
         @(posedge pclk);
         inc_pin <= 4'h0;
         dec_pin <= 4'h0;
         wt(4);
         cmp(steer_word[3], (i == 0) ? 48'h7 : 48'h0);
      end
      $display("pin test done");
   endtask
   task automatic t_phase;
      wr(ad(2, eds_pkg::OFS_CTRL), 32'h0000_0032);
      wr(ad(2, eds_pkg::OFS_TIMER), 32'h0000_0002);
      wr(ad(2, eds_pkg::OFS_PCW), 32'h0000_0064);
      wt(8);
      cmp({steer_word[2][47], steer_word[2] != '0, holdover[2]}, 48'h2);
      wt(16);
      cmp(holdover[2], 48'h1);
      eds_host_inst.xfer(1'h0, ad(2, eds_pkg::OFS_STATUS), 32'h0, rd, err);
      cmp(rd[0], 48'h1);
      wr(ad(2, eds_pkg::OFS_CTRL), 32'h0000_0032);
      wt(2);
      cmp(holdover[2], 48'h0);
      wr(ad(2, eds_pkg::OFS_CTRL), 32'h0000_0012);
      wr(ad(2, eds_pkg::OFS_PCW), 32'h0000_0064);
      wt(24);
      eds_host_inst.xfer(1'h0, ad(2, eds_pkg::OFS_PCW), 32'h0, rd, err);
      cmp(rd, 48'h0);
      $display("phase test done");
   endtask
   // ==========================================
   // run control
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_freq;
      t_step;
      t_pin;
      t_phase;
      tally_and_finish;
   end
   // tests need well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge pclk);
      failures++;
      tally_and_finish;
   end
endmodule
